// File: core/cpu_clock_select.sv
// CPU clock source selection, oscillator gating and switchover sequencing
`timescale 1ns/1ns
module cpu_clock_select
    import clk_ctrl_pkg::*;
#(
    parameter int STAB_COUNT = STAB_TICKS
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // CPU register access
    input  wire logic [15:0] addr,
    input  wire logic        wr_en,
    input  wire logic        wr_bit,
    input  wire logic [2:0]  bit_sel,
    input  wire logic [7:0]  wr_data,
    input  wire logic        rd_en,
    output logic      [7:0]  rd_data,
    // CPU standby requests
    input  wire logic        stop_req,
    input  wire logic        halt_req,
    input  wire logic        wake_req,
    // Subsystem oscillator output
    input  wire logic        sub_osc_in,
    // Oscillator controls
    output logic             main_osc_en,
    output logic             sub_osc_en,
    output logic             feedback_res_en,
    // Clock enables and CPU run status
    output logic             cpu_clk_en,
    output logic             instr_en,
    output logic             periph_clk_en,
    output logic             watch_clk_en,
    output logic             cpu_run
);

    // =========================================================
    // Write helper
    function automatic logic [7:0] wr_merge(
        input logic [7:0] old_v,
        input logic [7:0] mask,
        input logic       bit_mode,
        input logic [2:0] sel,
        input logic [7:0] data
    );
        logic [7:0] v;
        logic [7:0] one;
        one = 8'h01 << sel;
        v   = bit_mode ? ((old_v & ~one) | (data[0] ? one : 8'h00))
                       : data;
        return v & mask;
    endfunction : wr_merge

    // =========================================================
    // Registers
    logic [7:0]  proc_clk_ctrl_r;
    logic [7:0]  sub_osc_mode_r;
    logic [7:0]  subclk_sel_r;
    logic        active_src_r;
    logic        active_div_r;
    seq_state_t  state_r;
    seq_state_t  state_nxt;
    logic        halt_r;
    logic [STAB_W-1:0] stab_cnt_r;
    logic [2:0]  sw_cnt_r;
    logic        sw_use_sub_r;
    logic [7:0]  main_cnt_r;
    logic [1:0]  div4_cnt_r;
    logic        sub_s1_r;
    logic        sub_s2_r;
    logic        sub_s3_r;
    logic        sub_ph_r;
    logic        instr_ph_r;
    logic [7:0]  rd_data_r;

    // =========================================================
    // Decode
    wire hit_proc   = (addr == PROC_CLK_CTRL_ADDR);
    wire hit_mode   = (addr == SUB_OSC_MODE_ADDR);
    wire hit_subclk = (addr == SUBCLK_SEL_STAT_ADDR);
    wire wr_proc    = wr_en && hit_proc;
    wire wr_mode    = wr_en && hit_mode;
    wire wr_subclk  = wr_en && hit_subclk;

    wire main_stop  = proc_clk_ctrl_r[MAIN_OSC_STOP_BIT];
    wire req_div    = proc_clk_ctrl_r[MAIN_DIVIDE_SEL_BIT];
    wire req_src    = subclk_sel_r[SOURCE_SELECT_BIT];

    // Status bit comes from the completed switchover only
    wire [7:0] subclk_rd = {2'b00, active_src_r, req_src, 4'h0};

    wire [7:0] rd_mux = hit_proc   ? proc_clk_ctrl_r :
                        hit_mode   ? sub_osc_mode_r  :
                        hit_subclk ? subclk_rd       : 8'h00;

    // =========================================================
    // Oscillator enables
    // R1 main stop gating
    wire main_on = !main_stop && (state_r != ST_STOP);
    // R8 sub stop gating
    wire sub_on  = !sub_osc_mode_r[SUB_OSC_STOP_BIT];

    assign main_osc_en     = main_on;
    assign sub_osc_en      = sub_on;
    // R7 feedback resistor
    assign feedback_res_en = !sub_osc_mode_r[FEEDBACK_OFF_BIT];

    // =========================================================
    // Clock ticks
    wire main_last = (main_cnt_r == 8'(MAIN_DIV_CYC - 1));
    wire main_tick  = main_on && main_last;
    wire main4_tick = main_tick && (div4_cnt_r == 2'(MAIN_DIV4 - 1));
    wire sub_tick  = sub_on && sub_s2_r && !sub_s3_r;
    wire sub_half  = sub_tick && sub_ph_r;

    // R3 source and divider select
    wire old_tick = active_src_r ? sub_half :
                    active_div_r ? main4_tick : main_tick;

    wire clk_live = (state_r == ST_RUN) || (state_r == ST_SWITCH);
    assign cpu_clk_en    = old_tick && clk_live && !halt_r;
    // R6 two CPU clocks per instruction
    assign instr_en      = cpu_clk_en && instr_ph_r;
    // R18 peripherals on main only
    assign periph_clk_en = main_tick;
    assign watch_clk_en  = sub_tick;
    assign cpu_run       = clk_live && !halt_r;
    assign rd_data       = rd_data_r;

    // =========================================================
    // Sequencer
    wire cfg_change = (req_src != active_src_r) ||
                      (!req_src && (req_div != active_div_r));
    wire stab_done  = main_tick &&
                      (stab_cnt_r == STAB_W'(STAB_COUNT - 1));
    wire sw_dec     = sw_use_sub_r ? sub_tick : old_tick;
    wire sw_done    = sw_dec && (sw_cnt_r == 3'h1);
    // R18 STOP refused on subsystem source
    wire stop_ok    = stop_req && !active_src_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            // R17 stabilization wait
            ST_STAB:   if (stab_done) state_nxt = ST_RUN;
            ST_RUN: begin
                if (stop_ok) state_nxt = ST_STOP;
                else if (cfg_change) state_nxt = ST_SWITCH;
            end
            ST_SWITCH: if (sw_done) state_nxt = ST_RUN;
            ST_STOP:   if (wake_req) state_nxt = ST_STAB;
            default:   state_nxt = ST_STAB;
        endcase
    end

    // R16 old clock hold count
    wire [2:0] sw_load = (req_src && !active_src_r) ? SW_SUB_TICKS :
                         (!active_src_r && !active_div_r) ? SW_FAST_CLKS
                                                          : SW_SLOW_CLKS;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_STAB;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state_r != ST_STAB) begin
            stab_cnt_r <= '0;
        end else if (main_tick) begin
            stab_cnt_r <= stab_cnt_r + STAB_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sw_cnt_r     <= 3'h0;
            sw_use_sub_r <= 1'b0;
        end else if (state_r == ST_RUN && cfg_change) begin
            sw_cnt_r     <= sw_load;
            sw_use_sub_r <= req_src && !active_src_r;
        end else if (state_r == ST_SWITCH && sw_dec) begin
            sw_cnt_r     <= sw_cnt_r - 3'h1;
        end
    end

    // R19 status follows completed switch
    always_ff @(posedge clk) begin
        if (rst) begin
            active_src_r <= 1'b0;
            active_div_r <= 1'b1;
        end else if (sw_done && state_r == ST_SWITCH) begin
            active_src_r <= req_src;
            active_div_r <= req_div;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || wake_req) begin
            halt_r <= 1'b0;
        end else if (halt_req && clk_live) begin
            halt_r <= 1'b1;
        end
    end

    // =========================================================
    // Register writes
    // R2 processor control reset
    // R15 bit and byte writes
    always_ff @(posedge clk) begin
        if (rst) begin
            proc_clk_ctrl_r <= PROC_CLK_CTRL_RST;
        end else if (wr_proc) begin
            proc_clk_ctrl_r <= wr_merge(proc_clk_ctrl_r,
                PROC_CLK_CTRL_WMASK, wr_bit, bit_sel, wr_data);
        end
    end

    // R10 sub mode reset
    always_ff @(posedge clk) begin
        if (rst) begin
            sub_osc_mode_r <= SUB_OSC_MODE_RST;
        end else if (wr_mode) begin
            sub_osc_mode_r <= wr_merge(sub_osc_mode_r,
                SUB_OSC_MODE_WMASK, wr_bit, bit_sel, wr_data);
        end
    end

    // R12 source select, R14 reset, R11 status not writable
    always_ff @(posedge clk) begin
        if (rst) begin
            subclk_sel_r <= SUBCLK_SEL_STAT_RST;
        end else if (wr_subclk) begin
            subclk_sel_r <= wr_merge(subclk_sel_r,
                SUBCLK_SEL_WMASK, wr_bit, bit_sel, wr_data);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_r <= 8'h00;
        end else if (rd_en) begin
            rd_data_r <= rd_mux;
        end
    end

    // =========================================================
    // Dividers and synchroniser
    always_ff @(posedge clk) begin
        if (rst || !main_on || main_last) begin
            main_cnt_r <= 8'h00;
        end else begin
            main_cnt_r <= main_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div4_cnt_r <= 2'h0;
        end else if (main_tick) begin
            div4_cnt_r <= div4_cnt_r + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sub_s1_r <= 1'b0;
            sub_s2_r <= 1'b0;
            sub_s3_r <= 1'b0;
        end else begin
            sub_s1_r <= sub_osc_in;
            sub_s2_r <= sub_s1_r;
            sub_s3_r <= sub_s2_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sub_ph_r <= 1'b0;
        end else if (sub_tick) begin
            sub_ph_r <= !sub_ph_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            instr_ph_r <= 1'b0;
        end else if (cpu_clk_en) begin
            instr_ph_r <= !instr_ph_r;
        end
    end

    // =========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_MAIN_STOP: assert property ( // R1
        (main_stop || state_r == ST_STOP) |-> !main_osc_en)
        else $error("Main oscillator runs while stopped");

    AST_PROC_RESET: assert property (disable iff (1'b0) // R2
        rst |=> proc_clk_ctrl_r == PROC_CLK_CTRL_RST)
        else $error("Processor control reset value wrong");

    AST_SRC_TICK: assert property ( // R3
        cpu_clk_en |-> (active_src_r ? (watch_clk_en && sub_ph_r) :
            (periph_clk_en && (!active_div_r ||
             div4_cnt_r == 2'(MAIN_DIV4 - 1)))))
        else $error("CPU clock not from selected source");

    AST_INSTR_TWO: assert property ( // R6
        instr_en |-> $past(cpu_clk_en) || !$past(instr_ph_r) == 1'b0)
        else $error("Instruction pulse without two CPU clocks");

    AST_FB_RES: assert property ( // R7
        wr_mode && !wr_bit && wr_data[FEEDBACK_OFF_BIT]
        |=> !feedback_res_en)
        else $error("Feedback resistor still connected");

    AST_SUB_STOP: assert property ( // R8
        wr_mode && !wr_bit && wr_data[SUB_OSC_STOP_BIT]
        |=> !sub_osc_en && !watch_clk_en)
        else $error("Sub oscillator not stopped");

    AST_REGS_RESET: assert property (disable iff (1'b0) // R10
        rst |=> sub_osc_mode_r == 8'h00 && subclk_rd == 8'h00)
        else $error("Sub mode or subclock reset wrong");

    AST_STATUS_RO: assert property ( // R11
        $changed(active_src_r) |-> $past(state_r) == ST_SWITCH
        && $past(sw_done))
        else $error("Status bit changed without switchover");

    AST_BIT_WRITE: assert property ( // R15
        wr_proc && wr_bit && bit_sel == 3'h7 && wr_data[0]
        |=> main_stop && req_div == $past(req_div))
        else $error("Bit write disturbed other bits");

    AST_SWITCH_BOUND: assert property ( // R16
        $rose(state_r == ST_SWITCH) && !active_src_r
        && !sw_use_sub_r && main_on |-> ##[1:80] state_r != ST_SWITCH)
        else $error("Main switchover too long");

    AST_STAB_WAIT: assert property ( // R17
        state_r == ST_RUN && $past(state_r) == ST_STAB
        |-> $past(stab_cnt_r) == STAB_W'(STAB_COUNT - 1))
        else $error("CPU started before stabilization");

    AST_NO_STOP_SUB: assert property ( // R18
        stop_req && active_src_r && state_r == ST_RUN
        |=> state_r != ST_STOP)
        else $error("STOP taken on subsystem clock");

    COV_RUN: cover property ($rose(state_r == ST_RUN));
    COV_TO_SUB: cover property ($rose(active_src_r));
    COV_STOP_WAKE: cover property (
        state_r == ST_STOP ##1 state_r == ST_STAB);

endmodule : cpu_clock_select

// File: core/clk_ctrl_pkg.sv
// Constants and types for the CPU clock selection block
// Notes on behaviour
// R1 - Main stop bit 7 gates main oscillator; STOP instruction also halts it.
// R2 - Reset loads processor clock control with 02h: main clock divided by four.
// R3 - CPU clock: main, main/4, or subsystem clock halved regardless of divide.
// R4 - Software writes zero to bit 0 and bits 2 to 6 of processor control.
// R5 - Software sets main stop only while the subsystem clock drives the CPU.
// R6 - Shortest instruction lasts two periods of the selected CPU clock.
// R7 - Sub oscillator mode bit 1 set disconnects the on-chip feedback resistor.
// R8 - Sub oscillator mode bit 0 set stops the subsystem oscillator.
// R9 - Software writes zero to bits 2 to 7 of sub oscillator mode.
// R10 - Reset clears sub oscillator mode: oscillator runs, resistor connected.
// R11 - Read-only bit 5 of subclock register shows the actual CPU source.
// R12 - Bit 4 of subclock register selects main divided or subsystem source.
// R13 - Software writes zero to bits 0 to 3, 6 and 7 of subclock register.
// R14 - Reset clears subclock register, selecting the divided main clock.
// R15 - All three registers take single-bit and whole-byte writes.
// R16 - After a selection change the old clock runs on 2, 4 or ratio cycles.
// R17 - After reset the CPU waits 2^15 main clock periods before running.
// R18 - Subsystem source allows HALT not STOP; peripherals use main clock only.
// R19 - Status bit changes only once the switchover has really completed.
package clk_ctrl_pkg;

    // =========================================================
    // Register map
    localparam logic [15:0] SUB_OSC_MODE_ADDR     = 16'hfff0;
    localparam logic [15:0] SUBCLK_SEL_STAT_ADDR  = 16'hfff2;
    localparam logic [15:0] PROC_CLK_CTRL_ADDR    = 16'hfffb;

    localparam logic [7:0]  SUB_OSC_MODE_RST      = 8'h00;
    localparam logic [7:0]  SUBCLK_SEL_STAT_RST   = 8'h00;
    localparam logic [7:0]  PROC_CLK_CTRL_RST     = 8'h02;

    // =========================================================
    // Field positions and writable masks
    localparam int          MAIN_OSC_STOP_BIT     = 7;
    localparam int          MAIN_DIVIDE_SEL_BIT   = 1;
    localparam int          FEEDBACK_OFF_BIT      = 1;
    localparam int          SUB_OSC_STOP_BIT      = 0;
    localparam int          ACTIVE_SRC_STAT_BIT   = 5;
    localparam int          SOURCE_SELECT_BIT     = 4;
    localparam logic [7:0]  PROC_CLK_CTRL_WMASK   = 8'h82;
    localparam logic [7:0]  SUB_OSC_MODE_WMASK    = 8'h03;
    localparam logic [7:0]  SUBCLK_SEL_WMASK      = 8'h10;

    // =========================================================
    // Timing
    localparam int          CLK_HZ                = 20_000_000;
    localparam int          MAIN_OSC_FREQ_HZ      = 5_000_000;
    localparam int          MAIN_DIV_CYC          = CLK_HZ / MAIN_OSC_FREQ_HZ;
    localparam int          MAIN_DIV4             = 4;
    localparam int          STAB_EXP              = 15;
    localparam int          STAB_TICKS            = 2 ** STAB_EXP;
    localparam int          STAB_W                = 17;
    localparam logic [2:0]  SW_FAST_CLKS          = 3'h4;
    localparam logic [2:0]  SW_SLOW_CLKS          = 3'h2;
    localparam logic [2:0]  SW_SUB_TICKS          = 3'h2;

    // =========================================================
    // Sequencer states
    typedef enum logic [3:0] {
        ST_STAB   = 4'b0001,
        ST_RUN    = 4'b0010,
        ST_SWITCH = 4'b0100,
        ST_STOP   = 4'b1000
    } seq_state_t;

endpackage : clk_ctrl_pkg

// File: verif/sub_osc_model.sv
// Behavioural subsystem oscillator driving the raw wave into the block
`timescale 1ns/1ns
module sub_osc_model #(
    parameter int HALF_NS = 1013
) (
    // Run enable from the block
    input  wire logic en,
    // Raw oscillator wave
    output logic      wave
);
    // =========================================================
    // Oscillation
    initial wave = 1'b0;
    always begin
        #(HALF_NS);
        wave = en ? ~wave : 1'b0;
    end
endmodule : sub_osc_model

// File: verif/dual_oscillator_cpu_clock_select_bench.sv
// Self-checking bench for the CPU clock selection block
`timescale 1ns/1ns
module dual_oscillator_cpu_clock_select_bench;
    import clk_ctrl_pkg::*;
    localparam int SC    = 4;
    localparam int HALF  = 1013;
    localparam int SUB2  = 4 * HALF / 50;
    localparam int LIMIT = 20000;

    logic        clk, rst, wr_en, wr_bit, rd_en, stop_req, halt_req;
    logic        wake_req, sub_osc_in, main_osc_en, sub_osc_en;
    logic        feedback_res_en, cpu_clk_en, instr_en, periph_clk_en;
    logic        watch_clk_en, cpu_run, rd_dly;
    logic [15:0] addr;
    logic [2:0]  bit_sel;
    logic [7:0]  wr_data, rd_data, v;
    logic [7:0]  rd_q[$];
    logic [1:0]  sel;
    logic [3:0]  pz_all;
    int          n_fail, checked, cyc, n, i, last;

    assign pz_all = {watch_clk_en, periph_clk_en, instr_en, cpu_clk_en};

    // =========================================================
    // Design and partner
    cpu_clock_select #(.STAB_COUNT(SC)) cpu_clock_select_inst (
        .clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en),
        .wr_bit(wr_bit), .bit_sel(bit_sel), .wr_data(wr_data),
        .rd_en(rd_en), .rd_data(rd_data), .stop_req(stop_req),
        .halt_req(halt_req), .wake_req(wake_req),
        .sub_osc_in(sub_osc_in), .main_osc_en(main_osc_en),
        .sub_osc_en(sub_osc_en), .feedback_res_en(feedback_res_en),
        .cpu_clk_en(cpu_clk_en), .instr_en(instr_en),
        .periph_clk_en(periph_clk_en), .watch_clk_en(watch_clk_en),
        .cpu_run(cpu_run));

    sub_osc_model #(.HALF_NS(HALF)) sub_osc_model_inst (
        .en(sub_osc_en), .wave(sub_osc_in));

    always #25 clk = ~clk;

    // =========================================================
    // Compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_in(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("[FAIL] %0t count %0d not in %0d..%0d", $time,
                     got, lo, hi);
        end
    endtask : chk_in

    task automatic test_done;
        if (n_fail == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    // =========================================================
    // Drivers
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
                      input logic b, input logic [2:0] s);
        @(negedge clk);
        addr = a; wr_data = d; wr_bit = b; bit_sel = s; wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a; rd_en = 1'b1;
        rd_q.push_back(e);
        @(negedge clk);
        rd_en = 1'b0;
    endtask : rd

    task automatic pulse(input int w);
        @(negedge clk);
        {stop_req, halt_req, wake_req} = 3'b100 >> w;
        @(negedge clk);
        {stop_req, halt_req, wake_req} = 3'b000;
    endtask : pulse

    task automatic gap(input logic [1:0] s, output int g);
        int k;
        sel = s; k = 0; g = 0;
        @(negedge clk);
        while (pz_all[sel] !== 1'b1 && k < 400) begin
            @(negedge clk); k++;
        end
        do begin
            @(negedge clk); g++;
        end while (pz_all[sel] !== 1'b1 && g < 400);
    endtask : gap

    task automatic cnt(input logic [1:0] s, input int c, output int p);
        sel = s; p = 0;
        repeat (c) begin
            @(negedge clk);
            if (pz_all[sel] === 1'b1) p++;
        end
    endtask : cnt

    task automatic wait_run(output int w);
        w = 0;
        while (cpu_run !== 1'b1 && w < 2000) begin
            @(negedge clk); w++;
        end
    endtask : wait_run

    // =========================================================
    // Read monitor and timeout
    always @(posedge clk) rd_dly <= rd_en;
    always @(negedge clk) if (rd_dly === 1'b1 && rd_q.size() > 0)
        chk(rd_data, rd_q.pop_front());
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            test_done();
        end
    end

    // =========================================================
    // Main sequence
    initial begin
        clk = 0; rst = 1; addr = 0; wr_en = 0; wr_bit = 0; bit_sel = 0;
        wr_data = 0; rd_en = 0; stop_req = 0; halt_req = 0; wake_req = 0;
        rd_dly = 0; n_fail = 0; checked = 0; cyc = 0; sel = 0;
        n = $urandom(59973);
        repeat (3) @(negedge clk);
        rst = 0;
        chk({main_osc_en, sub_osc_en, feedback_res_en}, 3'h7);
        wait_run(n);
        chk_in(n, 4 * SC - 1, 4 * SC + 2);
        rd(PROC_CLK_CTRL_ADDR, 8'h02);
        rd(SUB_OSC_MODE_ADDR, 8'h00);
        rd(SUBCLK_SEL_STAT_ADDR, 8'h00);
        gap(2'h0, n); chk(n, 16);
        gap(2'h1, n); chk(n, 32);
        cnt(2'h2, 40, n); chk(n, 10);
        wr(16'h1234, 8'hff, 1'b0, 3'h0);
        rd(16'h1234, 8'h00);
        rd(PROC_CLK_CTRL_ADDR, 8'h02);
        for (i = 0; i < 4; i++) begin
            v = 8'($urandom()) & 8'h03;
            wr(SUB_OSC_MODE_ADDR, v, 1'b0, 3'h0);
            rd(SUB_OSC_MODE_ADDR, v);
            chk(feedback_res_en, !v[1]);
            chk(sub_osc_en, !v[0]);
        end
        wr(SUB_OSC_MODE_ADDR, 8'h01, 1'b1, 3'h1);
        wr(SUB_OSC_MODE_ADDR, 8'h00, 1'b1, 3'h0);
        rd(SUB_OSC_MODE_ADDR, 8'h02);
        wr(SUB_OSC_MODE_ADDR, 8'hff, 1'b0, 3'h0);
        rd(SUB_OSC_MODE_ADDR, 8'h03);
        wr(SUB_OSC_MODE_ADDR, 8'h00, 1'b0, 3'h0);
        wr(PROC_CLK_CTRL_ADDR, 8'h00, 1'b1, 3'h1);
        n = 0; last = -100;
        while (n < 400 && !(cpu_clk_en === 1'b1 && n - last == 4)) begin
            if (cpu_clk_en === 1'b1) last = n;
            @(negedge clk); n++;
        end
        chk_in(n, 4, 48);
        gap(2'h0, n); chk(n, 4);
        gap(2'h1, n); chk(n, 8);
        wr(PROC_CLK_CTRL_ADDR, 8'h7f, 1'b0, 3'h0);
        rd(PROC_CLK_CTRL_ADDR, 8'h02);
        repeat (80) @(negedge clk);
        wr(SUBCLK_SEL_STAT_ADDR, 8'h01, 1'b1, 3'h4);
        rd(SUBCLK_SEL_STAT_ADDR, 8'h10);
        repeat (3 * SUB2 / 2) @(negedge clk);
        rd(SUBCLK_SEL_STAT_ADDR, 8'h30);
        gap(2'h0, n); chk_in(n, SUB2 - 1, SUB2 + 2);
        pulse(0);
        repeat (4) @(negedge clk);
        chk({cpu_run, main_osc_en}, 2'h3);
        wr(PROC_CLK_CTRL_ADDR, 8'h01, 1'b1, 3'h7);
        chk(main_osc_en, 1'b0);
        rd(PROC_CLK_CTRL_ADDR, 8'h82);
        cnt(2'h2, 60, n); chk(n, 0);
        cnt(2'h3, 200, n); chk_in(n, 3, 6);
        wr(SUBCLK_SEL_STAT_ADDR, 8'h30, 1'b0, 3'h0);
        rd(SUBCLK_SEL_STAT_ADDR, 8'h30);
        wr(PROC_CLK_CTRL_ADDR, 8'h00, 1'b1, 3'h7);
        repeat (60) @(negedge clk);
        wr(SUBCLK_SEL_STAT_ADDR, 8'h20, 1'b0, 3'h0);
        rd(SUBCLK_SEL_STAT_ADDR, 8'h20);
        repeat (3 * SUB2) @(negedge clk);
        rd(SUBCLK_SEL_STAT_ADDR, 8'h00);
        gap(2'h0, n); chk(n, 16);
        pulse(1);
        repeat (3) @(negedge clk);
        chk(cpu_run, 1'b0);
        cnt(2'h0, 40, n); chk(n, 0);
        pulse(2);
        repeat (3) @(negedge clk);
        chk(cpu_run, 1'b1);
        pulse(0);
        repeat (3) @(negedge clk);
        chk({main_osc_en, cpu_run}, 2'h0);
        pulse(2);
        wait_run(n);
        chk_in(n, 4 * SC - 1, 4 * SC + 4);
        repeat (4) @(negedge clk);
        test_done();
    end
endmodule : dual_oscillator_cpu_clock_select_bench
